/* hw/srp_device.sv */
// Overview of operation
// - Host sends write flag as zero.
// - Device shifts data on rising serial clock.
// - Host holds select low whole frame.
// - Select high: clocks ignored, register unchanged.
// - Unaddressed devices keep select high.
// - Use mode zero; mode three adds gap.
// - Host sends read flag as one.
// - Readback pin low during address bits.
// - Readback bit launched after falling edge.
// - Data input ignored during readback data.
`timescale 1ns/100ps
`default_nettype none
`include "srp_regs.svh"
module srp_device (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  srp_link_if.device link,
  input wire logic [`SRP_DATA_BITS-1:0] read_data,
  output logic [`SRP_ADDR_BITS-1:0] reg_addr,
  output logic [`SRP_DATA_BITS-1:0] write_data,
  output logic write_strobe,
  output logic read_strobe
);
  logic [1:0] cs_sync;
  logic [1:0] sck_sync;
  logic [1:0] sdi_sync;
  logic sck_prev;
  logic cs_prev;
  logic [`SRP_FRAME_BITS-1:0] shift;
  logic [`SRP_CNT_W-1:0] count;
  logic [`SRP_DATA_BITS-1:0] read_shift;
  logic read_flag;
  logic reading;
  logic miso;
  logic sck_rise;
  logic sck_fall;
  logic selected;
  logic frame_end;
  logic addr_done;
  logic data_fall;
  logic first_data_fall;

  // Every pin passes two flip-flops before any logic reads it.
  // Select resets high so that no frame appears to start at reset.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cs_sync <= 2'h3;
    end else if (clk_en) begin
      cs_sync <= {cs_sync[0], link.chip_select_n};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sck_sync <= 2'h0;
    end else if (clk_en) begin
      sck_sync <= {sck_sync[0], link.serial_clock};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sdi_sync <= 2'h0;
    end else if (clk_en) begin
      sdi_sync <= {sdi_sync[0], link.serial_data_in};
    end
  end

  // Edge detectors start at the idle level of their pins, so reset makes no false edge.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sck_prev <= 1'h0;
      cs_prev <= 1'h1;
    end else if (clk_en) begin
      sck_prev <= sck_sync[1];
      cs_prev <= cs_sync[1];
    end
  end

  assign selected = !cs_sync[1];
  assign sck_rise = selected && sck_sync[1] && !sck_prev;
  assign sck_fall = selected && !sck_sync[1] && sck_prev;
  assign frame_end = cs_sync[1] && !cs_prev;
  assign reading = (count != `SRP_CNT_RESET) && (read_flag == `SRP_FLAG_READ);
  assign addr_done = sck_rise && reading && (count == `SRP_ADDR_END);
  assign data_fall = sck_fall && reading && (count >= `SRP_READ_START);
  assign first_data_fall = data_fall && (count == `SRP_READ_START);

  // The bit counter stops at a full frame, so extra clocks cannot wrap it.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count <= `SRP_CNT_RESET;
    end else if (clk_en) begin
      if (!selected) begin
        count <= `SRP_CNT_RESET;
      end else if (sck_rise && count != `SRP_FRAME_END) begin
        count <= count + 5'h01;
      end
    end
  end

  // The read flag is the first bit of every frame.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      read_flag <= 1'h0;
    end else if (clk_en) begin
      if (!selected) begin
        read_flag <= 1'h0;
      end else if (sck_rise && count == `SRP_CNT_RESET) begin
        read_flag <= sdi_sync[1];
      end
    end
  end

  // The shift register moves only on rising edges while selected.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      shift <= '0;
    end else if (clk_en && sck_rise) begin
      if (reading && count >= `SRP_READ_START) begin
        shift <= {shift[`SRP_FRAME_BITS-2:0], 1'h0};
      end else begin
        shift <= {shift[`SRP_FRAME_BITS-2:0], sdi_sync[1]};
      end
    end
  end

  // The address is complete at the eighth rising edge; read_data is taken at the next fall.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_addr <= '0;
    end else if (clk_en && sck_rise && count == `SRP_ADDR_END) begin
      reg_addr <= {shift[`SRP_ADDR_BITS-2:0], sdi_sync[1]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      read_strobe <= 1'h0;
    end else if (clk_en) begin
      read_strobe <= addr_done;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      read_shift <= '0;
    end else if (clk_en) begin
      if (first_data_fall) begin
        read_shift <= {read_data[`SRP_DATA_BITS-2:0], 1'h0};
      end else if (data_fall) begin
        read_shift <= {read_shift[`SRP_DATA_BITS-2:0], 1'h0};
      end
    end
  end

  // Address bits drive zero; data bits change only after falling edges.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      miso <= 1'h0;
    end else if (clk_en) begin
      if (!selected) begin
        miso <= 1'h0;
      end else if (first_data_fall) begin
        miso <= read_data[`SRP_DATA_BITS-1];
      end else if (data_fall) begin
        miso <= read_shift[`SRP_DATA_BITS-1];
      end else if (sck_fall) begin
        miso <= 1'h0;
      end
    end
  end

  // A short frame commits nothing; the counter is still full when select is seen high.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      write_data <= '0;
      write_strobe <= 1'h0;
    end else if (clk_en) begin
      write_strobe <= 1'h0;
      if (frame_end && count == `SRP_FRAME_END && read_flag == `SRP_FLAG_WRITE) begin
        write_data <= shift[`SRP_DATA_BITS-1:0];
        write_strobe <= 1'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      link.readback_output_pin <= 1'h0;
    end else if (clk_en) begin
      link.readback_output_pin <= miso;
    end
  end
endmodule
`default_nettype wire

/* pkg/srp_regs.svh */
`ifndef SRP_REGS_SVH
`define SRP_REGS_SVH

// Frame layout: flag, address, data, most significant bit first.
`define SRP_FRAME_BITS 24
`define SRP_ADDR_BITS 7
`define SRP_DATA_BITS 16
`define SRP_FLAG_POS 23
`define SRP_ADDR_MSB 22
`define SRP_ADDR_LSB 16
`define SRP_FLAG_WRITE 1'h0
`define SRP_FLAG_READ 1'h1
`define SRP_CNT_W 5
`define SRP_CNT_RESET 5'h00
`define SRP_READ_START 5'h08
`define SRP_ADDR_END 5'h07
`define SRP_FRAME_END 5'h18
`define SRP_LAST_BIT 5'h17
// Host-side serial clock divider: half period in system clocks, less one.
`define SRP_SCK_HALF 3'h4
// Select-high gap between frames, in system clocks; srp_host does not read it and times its gap with SRP_SCK_HALF.
`define SRP_CS_GAP 3'h4

`endif

/* pkg/srp_pkg.sv */
package srp_pkg;
  typedef enum logic [1:0] {
    SRP_H_IDLE = 2'b00,
    SRP_H_LOW = 2'b01,
    SRP_H_HIGH = 2'b10,
    SRP_H_GAP = 2'b11
  } srp_host_state_t;
endpackage

/* pkg/srp_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface srp_link_if;
  logic chip_select_n;
  logic serial_clock;
  logic serial_data_in;
  logic readback_output_pin;
  modport device (
    input chip_select_n,
    input serial_clock,
    input serial_data_in,
    output readback_output_pin
  );
  modport host (
    output chip_select_n,
    output serial_clock,
    output serial_data_in,
    input readback_output_pin
  );
endinterface
`default_nettype wire

/* hw/srp_host.sv */
`timescale 1ns/100ps
`default_nettype none
`include "srp_regs.svh"
module srp_host (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  srp_link_if.host link,
  input wire logic start,
  input wire logic rd_wr_n,
  input wire logic [`SRP_ADDR_BITS-1:0] addr,
  input wire logic [`SRP_DATA_BITS-1:0] wdata,
  output logic busy,
  output logic done,
  output logic [`SRP_DATA_BITS-1:0] rdata
);
  srp_pkg::srp_host_state_t state;
  logic [`SRP_FRAME_BITS-1:0] frame;
  logic [`SRP_CNT_W-1:0] bits;
  logic [2:0] tick;
  logic [1:0] miso_sync;
  logic is_read;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      miso_sync <= 2'h0;
    end else if (clk_en) begin
      miso_sync <= {miso_sync[0], link.readback_output_pin};
    end
  end

  // Mode zero: clock idles low, data set while low, device samples on rise.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= srp_pkg::SRP_H_IDLE;
      link.chip_select_n <= 1'h1;
      link.serial_clock <= 1'h0;
      link.serial_data_in <= 1'h0;
      frame <= '0;
      bits <= `SRP_CNT_RESET;
      tick <= 3'h0;
      busy <= 1'h0;
      done <= 1'h0;
      rdata <= '0;
      is_read <= 1'h0;
    end else if (clk_en) begin
      done <= 1'h0;
      case (state)
        srp_pkg::SRP_H_IDLE: begin
          if (start) begin
            frame <= {rd_wr_n ? `SRP_FLAG_READ : `SRP_FLAG_WRITE, addr, wdata};
            is_read <= rd_wr_n;
            link.chip_select_n <= 1'h0;
            busy <= 1'h1;
            bits <= `SRP_CNT_RESET;
            tick <= 3'h0;
            state <= srp_pkg::SRP_H_LOW;
          end
        end
        srp_pkg::SRP_H_LOW: begin
          link.serial_data_in <= frame[`SRP_FRAME_BITS-1];
          if (tick == `SRP_SCK_HALF) begin
            tick <= 3'h0;
            link.serial_clock <= 1'h1;
            state <= srp_pkg::SRP_H_HIGH;
          end else begin
            tick <= tick + 3'h1;
          end
        end
        srp_pkg::SRP_H_HIGH: begin
          if (tick == `SRP_SCK_HALF) begin
            tick <= 3'h0;
            link.serial_clock <= 1'h0;
            frame <= {frame[`SRP_FRAME_BITS-2:0], 1'h0};
            // Each data bit is taken one full bit after the fall that launched it.
            if (is_read && bits >= `SRP_READ_START) begin
              rdata <= {rdata[`SRP_DATA_BITS-2:0], miso_sync[1]};
            end
            bits <= bits + 5'h01;
            if (bits == `SRP_LAST_BIT) begin
              state <= srp_pkg::SRP_H_GAP;
            end else begin
              state <= srp_pkg::SRP_H_LOW;
            end
          end else begin
            tick <= tick + 3'h1;
          end
        end
        srp_pkg::SRP_H_GAP: begin
          if (tick == `SRP_SCK_HALF) begin
            if (link.chip_select_n) begin
              busy <= 1'h0;
              done <= 1'h1;
              state <= srp_pkg::SRP_H_IDLE;
            end else begin
              link.chip_select_n <= 1'h1;
            end
            tick <= 3'h0;
          end else begin
            tick <= tick + 3'h1;
          end
        end
        default: begin
          state <= srp_pkg::SRP_H_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* test/srp_link_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module srp_link_checker (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  input wire logic readback_output_pin
);
  logic [4:0] bit_cnt;
  logic sclk_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk_sys) begin
    sclk_q <= serial_clock;
  end
  // Rising serial clock edges seen in the current frame.
  always_ff @(posedge clk_sys) begin
    if (sys_rst || chip_select_n) begin
      bit_cnt <= 5'h00;
    end else if (serial_clock && !sclk_q) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end
  property p_idle_clk; chip_select_n |-> !serial_clock; endproperty
  a_idle_clk: assert property (p_idle_clk)
    else $error("serial clock high while deselected");
  property p_bit_high; $rose(serial_clock) |-> serial_clock[*5] ##1 !serial_clock; endproperty
  a_bit_high: assert property (p_bit_high)
    else $error("serial clock high phase wrong");
  property p_data_stable; serial_clock && sclk_q |-> $stable(serial_data_in); endproperty
  a_data_stable: assert property (p_data_stable)
    else $error("serial data moved while clock high");
  property p_bit_count; $rose(chip_select_n) |-> !serial_clock && bit_cnt == 5'h18; endproperty
  a_bit_count: assert property (p_bit_count)
    else $error("frame did not carry 24 bits");
  property p_gap; $rose(chip_select_n) |-> chip_select_n[*5]; endproperty
  a_gap: assert property (p_gap)
    else $error("select high gap too short");
  property p_frame_len; $fell(chip_select_n) |-> ##[230:260] $rose(chip_select_n); endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("select low for wrong length");
  property p_addr_low; !chip_select_n && bit_cnt < 5'h08 |-> !readback_output_pin; endproperty
  a_addr_low: assert property (p_addr_low)
    else $error("readback pin high during address");
  property p_launch; $changed(readback_output_pin) |-> !serial_clock; endproperty
  a_launch: assert property (p_launch)
    else $error("readback pin moved while clock high");
  c_frame: cover property ($rose(chip_select_n));
  c_pin_high: cover property (readback_output_pin);
  c_full: cover property (bit_cnt == 5'h18);
endmodule
`default_nettype wire

/* test/serial_register_port_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module serial_register_port_tb;
  logic clk_sys, sys_rst, start, rd_wr_n, write_strobe, read_strobe, busy, done;
  logic [6:0] addr, reg_addr, rs_addr;
  logic [15:0] wdata, rdata, read_data, write_data;
  logic [15:0] mem [128];
  int err_total, n_checks, seed, n_ws, exp_ws, i;
  srp_link_if link();
  srp_device i_srp_device (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(1'b1),
    .link(link.device), .read_data(read_data), .reg_addr(reg_addr),
    .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe));
  srp_host i_srp_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(1'b1),
    .link(link.host), .start(start), .rd_wr_n(rd_wr_n), .addr(addr), .wdata(wdata),
    .busy(busy), .done(done), .rdata(rdata));
  srp_link_checker i_srp_link_checker (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .chip_select_n(link.chip_select_n), .serial_clock(link.serial_clock),
    .serial_data_in(link.serial_data_in), .readback_output_pin(link.readback_output_pin));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    if (write_strobe === 1'b1) n_ws++;
    if (read_strobe === 1'b1) rs_addr = reg_addr;
  end
  // The bench model is the register file behind the device.
  always @(negedge clk_sys) read_data <= mem[reg_addr];
  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_addr(input logic [6:0] got, input logic [6:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("errors=%0d checks=%0d", err_total, n_checks);
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wait_hi(ref logic sig, input int lim);
    int k;
    for (k = 0; k < lim && sig !== 1'b1; k++) @(negedge clk_sys);
    if (k == lim) begin
      err_total++;
      $display("CHECK FAILED t=%0t timeout got=0 exp=1", $time);
      finish_test();
    end
  endtask
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    start = 1'b1;
    rd_wr_n = rd;
    addr = a;
    wdata = d;
    // A request held on while busy must be ignored.
    @(negedge clk_sys);
    addr = ~a;
    wdata = ~d;
    repeat (2) @(negedge clk_sys);
    start = 1'b0;
    wait_hi(done, 400);
    chk_data({15'h0000, link.chip_select_n}, 16'h0001);
    if (rd) begin
      chk_data(rdata, mem[a]);
      chk_addr(rs_addr, a);
    end else begin
      chk_data(n_ws[15:0], exp_ws[15:0] + 16'h0001);
      chk_addr(reg_addr, a);
      chk_data(write_data, d);
      mem[a] = d;
      exp_ws++;
    end
  endtask
  initial begin
    seed = 32'h46af;
    err_total = 0;
    n_checks = 0;
    n_ws = 0;
    exp_ws = 0;
    sys_rst = 1'b1;
    start = 1'b0;
    rd_wr_n = 1'b0;
    addr = 7'h00;
    wdata = 16'h0000;
    read_data = 16'h0000;
    for (i = 0; i < 128; i++) mem[i] = $random(seed);
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    xfer(1'b0, 7'h7F, 16'hFFFF);
    xfer(1'b1, 7'h7F, 16'h0000);
    xfer(1'b1, 7'h00, 16'h0000);
    for (i = 0; i < 16; i++) xfer($random(seed), $random(seed) & 7'h07, $random(seed));
    chk_data(n_ws[15:0], exp_ws[15:0]);
    finish_test();
  end
endmodule
`default_nettype wire
